// ---- sfp_pkg.sv ----
// Shared constants and types for the serial flash erase/program link
package sfp_pkg;

	// ****
	// Opcodes
	// ****
	localparam logic [7:0] OP_UNLOCK  = 8'h06;
	localparam logic [7:0] OP_GUNLOCK = 8'h98;
	localparam logic [7:0] OP_SE      = 8'h20;
	localparam logic [7:0] OP_SE_W    = 8'h21;
	localparam logic [7:0] OP_B32     = 8'h52;
	localparam logic [7:0] OP_B32_W   = 8'h5c;
	localparam logic [7:0] OP_B64     = 8'hd8;
	localparam logic [7:0] OP_B64_W   = 8'hdc;
	localparam logic [7:0] OP_CE0     = 8'h60;
	localparam logic [7:0] OP_CE1     = 8'hc7;
	localparam logic [7:0] OP_PP      = 8'h02;
	localparam logic [7:0] OP_PP_W    = 8'h12;

	// ****
	// Array geometry and protection
	// ****
	localparam int         ADDR_W       = 26;
	localparam logic [2:0] NARROW_BYTES = 3'h3;
	localparam logic [2:0] WIDE_BYTES   = 3'h4;
	localparam logic [4:0] SECT_LSB     = 5'h0c;
	localparam logic [4:0] B32_LSB      = 5'h0f;
	localparam logic [4:0] B64_LSB      = 5'h10;
	localparam logic [10:0] NUM_BLOCKS  = 11'h400;
	localparam logic [3:0] ALL_LEVEL    = 4'hb;

	// ****
	// Timing
	// ****
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned LINK_PERIOD_NS = 80;
	localparam int unsigned SCK_HALF = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0]  CS_GAP_CYC = 4'hc;

	// ****
	// Controller registers
	// ****
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_LEN  = 8'h08;
	localparam logic [7:0] REG_SEED = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int CTRL_NADDR_LSB = 8;
	localparam int CTRL_QUAD_BIT  = 12;
	localparam int CTRL_EXTRA_LSB = 16;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****
	// Types
	// ****
	typedef enum logic [7:0] {
		K_NONE    = 8'h01,
		K_UNLOCK  = 8'h02,
		K_GUNLOCK = 8'h04,
		K_SECT    = 8'h08,
		K_B32     = 8'h10,
		K_B64     = 8'h20,
		K_CHIP    = 8'h40,
		K_PROG    = 8'h80
	} sfp_kind_t;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_OPC  = 5'h02,
		RX_ADDR = 5'h04,
		RX_DATA = 5'h08,
		RX_SKIP = 5'h10
	} sfp_rx_t;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'h1,
		HS_SHIFT = 3'h2,
		HS_GAP   = 3'h4
	} sfp_hs_t;

endpackage : sfp_pkg

// ---- sfp_link_if.sv ----
// Serial link between controller and flash end
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
	logic       csN;
	logic       sclk;
	logic [3:0] dq;
	modport ctrl  (output csN, sclk, dq);
	modport flash (input csN, sclk, dq);
endinterface : sfp_link_if
`default_nettype wire

// ---- sfp_flash_end.sv ----
// Flash end: erase and page-write command decoding and sequencing
//
// Functional notes
// - 20H erases addressed sector to ones
// - Host sets write latch before erase/program
// - Sector chosen by address bits down to A12
// - Erase ends exactly on byte boundary, else rejected
// - Host sends opcode, address, then raises select
// - Internal cycle starts at select rising edge
// - Busy flag held, then cleared with latch
// - Protected region is never erased or written
// - Four-byte mode makes addresses 32 bits
// - 21H sector erase always 32-bit address
// - 52H erases enclosing 32K block
// - 5CH 32K erase with 32-bit address
// - D8H erases enclosing 64K block
// - DCH 64K erase with 32-bit address
// - 60H or C7H alone erases whole array
// - In per-block lock mode, host sends global unlock before array erase
// - Page write keeps only last 256 bytes
// - Column wraps to page start, not next page
// - Short data written from requested column
// - Page write needs whole data bytes, else rejected
// - Host should write whole aligned pages once
// - 12H page write with 32-bit address
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_end
	import sfp_pkg::*;
#(
	parameter int unsigned SMALL_WIPE_US = 60,
	parameter int unsigned LARGE_WIPE_US = 200,
	parameter int unsigned ARRAY_WIPE_US = 2000,
	parameter int unsigned PAGE_WRITE_US = 5
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	sfp_link_if.flash              link,
	input  wire logic              addr4Mode,
	input  wire logic              quadCmdMode,
	input  wire logic [4:0]        protectLevel,
	input  wire logic              perBlockLockMode,
	output var  logic              opInProgressFlag,
	output var  logic              writeLatch,
	output var  logic              cmdRejected,
	output var  logic              memErase,
	output var  sfp_kind_t         memKind,
	output var  logic [ADDR_W-1:0] memEraseAddr,
	output var  logic              memWr,
	output var  logic [ADDR_W-1:0] memWrAddr,
	output var  logic [7:0]        memWrData
);

	localparam int unsigned SMALL_CYC = SMALL_WIPE_US * CLK_MHZ;
	localparam int unsigned LARGE_CYC = LARGE_WIPE_US * CLK_MHZ;
	localparam int unsigned ARRAY_CYC = ARRAY_WIPE_US * CLK_MHZ;
	localparam int unsigned PAGE_CYC  = PAGE_WRITE_US * CLK_MHZ;

	// ****
	// Link synchronisers
	// ****
	logic       csS1, csS2, csS3;
	logic       sckS1, sckS2, sckS3;
	logic [3:0] dqS1, dqS2;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{csS1, csS2, csS3}    <= 3'h7;
			{sckS1, sckS2, sckS3} <= 3'h0;
			{dqS1, dqS2}          <= 8'h00;
		end else begin
			{csS1, csS2, csS3}    <= {link.csN, csS1, csS2};
			{sckS1, sckS2, sckS3} <= {link.sclk, sckS1, sckS2};
			{dqS1, dqS2}          <= {link.dq, dqS1};
		end
	end

	logic csLow, csRise, sckRise;
	assign csLow   = !csS2;
	assign csRise  = csS2 && !csS3;
	assign sckRise = sckS2 && !sckS3;

	// ****
	// Bit and byte assembly
	// ****
	sfp_rx_t     rxR;
	sfp_kind_t   kindR;
	logic [7:0]  shR;
	logic [2:0]  bitCntR;
	logic [2:0]  addrLeftR;
	logic [31:0] addrR;
	logic [7:0]  colR;
	logic        exactR;
	logic        gotDataR;
	logic        busyR;
	logic        gbuR;

	logic [2:0] step;
	logic [2:0] bitCntNxt;
	logic       byteDone;
	logic [7:0] byteNxt;

	always_comb begin
		step      = quadCmdMode ? 3'h4 : 3'h1;
		bitCntNxt = bitCntR + step;
		byteDone  = (bitCntNxt == 3'h0);
		byteNxt   = quadCmdMode ? {shR[3:0], dqS2} : {shR[6:0], dqS2[0]};
	end

	// Opcode decode
	sfp_kind_t opKind;
	logic      opWide;
	logic      opAddressed;

	always_comb begin
		opWide = 1'b0;
		case (byteNxt)
			OP_UNLOCK:  opKind = K_UNLOCK;
			OP_GUNLOCK: opKind = K_GUNLOCK;
			OP_CE0:     opKind = K_CHIP;
			OP_CE1:     opKind = K_CHIP;
			OP_SE:      opKind = K_SECT;
			OP_B32:     opKind = K_B32;
			OP_B64:     opKind = K_B64;
			OP_PP:      opKind = K_PROG;
			OP_SE_W:    {opKind, opWide} = {K_SECT, 1'b1};
			OP_B32_W:   {opKind, opWide} = {K_B32, 1'b1};
			OP_B64_W:   {opKind, opWide} = {K_B64, 1'b1};
			OP_PP_W:    {opKind, opWide} = {K_PROG, 1'b1};
			default:    opKind = K_NONE;
		endcase
		// Busy drops erase, write, unlock
		if (busyR && opKind != K_GUNLOCK) begin
			opKind = K_NONE;
		end
		opAddressed = (opKind == K_SECT) || (opKind == K_B32) ||
			(opKind == K_B64) || (opKind == K_PROG);
	end

	logic opcStrobe;
	logic dataStrobe;
	assign opcStrobe  = csLow && rxR == RX_OPC && sckRise && byteDone;
	assign dataStrobe = csLow && rxR == RX_DATA && sckRise && byteDone;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxR       <= RX_IDLE;
			kindR     <= K_NONE;
			shR       <= 8'h00;
			bitCntR   <= 3'h0;
			addrLeftR <= 3'h0;
			addrR     <= 32'h0;
			colR      <= 8'h00;
			exactR    <= 1'b0;
			gotDataR  <= 1'b0;
		end else if (!csLow) begin
			rxR     <= RX_IDLE;
			bitCntR <= 3'h0;
		end else if (rxR == RX_IDLE) begin
			rxR      <= RX_OPC;
			kindR    <= K_NONE;
			exactR   <= 1'b0;
			gotDataR <= 1'b0;
		end else if (sckRise) begin
			bitCntR <= bitCntNxt;
			shR     <= byteNxt;
			case (rxR)
				RX_OPC: begin
					if (byteDone) begin
						kindR <= opKind;
						addrR <= 32'h0;
						if (opAddressed) begin
							rxR <= RX_ADDR;
							addrLeftR <= (opWide || addr4Mode) ?
								WIDE_BYTES : NARROW_BYTES;
						end else begin
							rxR    <= RX_SKIP;
							exactR <= (opKind != K_NONE);
						end
					end
				end
				RX_ADDR: begin
					if (byteDone) begin
						addrR     <= {addrR[23:0], byteNxt};
						addrLeftR <= addrLeftR - 3'h1;
						if (addrLeftR == 3'h1) begin
							if (kindR == K_PROG) begin
								rxR  <= RX_DATA;
								colR <= byteNxt;
							end else begin
								rxR    <= RX_SKIP;
								exactR <= 1'b1;
							end
						end
					end
				end
				RX_DATA: begin
					if (byteDone) begin
						colR     <= colR + 8'h01;
						gotDataR <= 1'b1;
					end
				end
				default: exactR <= 1'b0;
			endcase
		end
	end

	// ****
	// Page buffer
	// ****
	logic [7:0]   bufR [256];
	logic [255:0] maskR;

	always_ff @(posedge clk) begin
		if (dataStrobe) begin
			bufR[colR] <= byteNxt;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			maskR <= '0;
		end else if (opcStrobe && opKind == K_PROG) begin
			maskR <= '0;
		end else if (dataStrobe) begin
			maskR[colR] <= 1'b1;
		end
	end

	// ****
	// Command acceptance at select rise
	// ****
	logic        boundary, isOp, protHit, goOk, unlockOk, gbuOk;
	logic [3:0]  lvl;
	logic [10:0] nBlk;
	logic [10:0] blk;

	always_comb begin
		lvl  = protectLevel[3:0];
		blk  = {1'b0, addrR[ADDR_W-1:16]};
		if (lvl == 4'h0) begin
			nBlk = 11'h000;
		end else if (lvl >= ALL_LEVEL) begin
			nBlk = NUM_BLOCKS;
		end else begin
			nBlk = 11'h001 << (lvl - 4'h1);
		end
		if (kindR == K_CHIP) begin
			protHit = (lvl != 4'h0);
		end else if (protectLevel[4]) begin
			protHit = (blk < nBlk);
		end else begin
			protHit = (blk >= NUM_BLOCKS - nBlk);
		end
		boundary = (rxR == RX_SKIP && exactR) || (rxR == RX_DATA &&
			gotDataR && bitCntR == 3'h0);
		isOp = opAddressedKind(kindR) || kindR == K_CHIP;
		goOk = csRise && boundary && isOp && writeLatch && !busyR &&
			!protHit &&
			(kindR != K_CHIP || !perBlockLockMode || gbuR);
		unlockOk = csRise && boundary && kindR == K_UNLOCK;
		gbuOk    = csRise && boundary && kindR == K_GUNLOCK;
	end

	function automatic logic opAddressedKind(input sfp_kind_t k);
		return k == K_SECT || k == K_B32 || k == K_B64 || k == K_PROG;
	endfunction : opAddressedKind

	// ****
	// Self-timed cycle
	// ****
	logic [31:0]       timerR;
	logic [4:0]        eraseLsb;
	logic [ADDR_W-1:0] eraseAddr;
	logic              done;

	assign done = busyR && timerR == 32'h0;

	always_comb begin
		case (kindR)
			K_SECT:  eraseLsb = SECT_LSB;
			K_B32:   eraseLsb = B32_LSB;
			default: eraseLsb = B64_LSB;
		endcase
		eraseAddr = addrR[ADDR_W-1:0] &
			~((ADDR_W'(1) << eraseLsb) - ADDR_W'(1));
		if (kindR == K_CHIP) begin
			eraseAddr = '0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busyR        <= 1'b0;
			timerR       <= 32'h0;
			memErase     <= 1'b0;
			memKind      <= K_NONE;
			memEraseAddr <= '0;
			cmdRejected  <= 1'b0;
		end else begin
			memErase    <= 1'b0;
			cmdRejected <= csRise && isOp && !goOk;
			if (goOk) begin
				busyR        <= 1'b1;
				memErase     <= (kindR != K_PROG);
				memKind      <= kindR;
				memEraseAddr <= eraseAddr;
				case (kindR)
					K_SECT:  timerR <= 32'(SMALL_CYC - 1);
					K_CHIP:  timerR <= 32'(ARRAY_CYC - 1);
					K_PROG:  timerR <= 32'(PAGE_CYC - 1);
					default: timerR <= 32'(LARGE_CYC - 1);
				endcase
			end else if (done) begin
				busyR <= 1'b0;
			end else if (busyR) begin
				timerR <= timerR - 32'h1;
			end
		end
	end

	assign opInProgressFlag = busyR;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			writeLatch <= 1'b0;
		end else if (unlockOk) begin
			writeLatch <= 1'b1;
		end else if (done) begin
			writeLatch <= 1'b0;
		end
	end

	// Global unlock covers exactly one array erase
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gbuR <= 1'b0;
		end else if (gbuOk) begin
			gbuR <= 1'b1;
		end else if (goOk && kindR == K_CHIP) begin
			gbuR <= 1'b0;
		end
	end

	// ****
	// Page write-out, one column per cycle
	// ****
	logic                scanR;
	logic [7:0]          idxR;
	logic [ADDR_W-9:0]   pageR;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scanR     <= 1'b0;
			idxR      <= 8'h00;
			pageR     <= '0;
			memWr     <= 1'b0;
			memWrAddr <= '0;
			memWrData <= 8'h00;
		end else if (goOk && kindR == K_PROG) begin
			scanR <= 1'b1;
			idxR  <= 8'h00;
			pageR <= addrR[ADDR_W-1:8];
			memWr <= 1'b0;
		end else if (scanR) begin
			memWr     <= maskR[idxR];
			memWrAddr <= {pageR, idxR};
			memWrData <= bufR[idxR];
			idxR      <= idxR + 8'h01;
			scanR     <= (idxR != 8'hff);
		end else begin
			memWr <= 1'b0;
		end
	end

endmodule : sfp_flash_end
`default_nettype wire

// ---- sfp_host_end.sv ----
// Controller end: AXI4-Lite registers driving the serial flash link
`timescale 1ns/1ps
`default_nettype none
module sfp_host_end
	import sfp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	sfp_link_if.ctrl         link,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready
);

	// ****
	// Register slave
	// ****
	logic [31:0] ctrlR, addrR, lenR, seedR, wD;
	logic [7:0]  awA;
	logic [3:0]  wS;
	logic        awHeldR, wHeldR, goR, write_unlock_cmd, busy;
	sfp_hs_t     hsR;

	assign write_unlock_cmd = awHeldR && wHeldR && !bvalid;
	assign busy = goR || hsR != HS_IDLE;

	function automatic logic [31:0] mrg(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction : mrg

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{awready, wready, awHeldR, wHeldR, bvalid} <= 5'h18;
			awA     <= 8'h00;
			wD      <= 32'h0;
			wS      <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awA     <= awaddr;
				awHeldR <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wD     <= wdata;
				wS     <= wstrb;
				wHeldR <= 1'b1;
				wready <= 1'b0;
			end
			if (write_unlock_cmd) begin
				bvalid <= 1'b1;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awHeldR <= 1'b0;
				wHeldR  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrlR <= 32'h0;
			addrR <= 32'h0;
			lenR  <= 32'h0;
			seedR <= 32'h0;
			goR   <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			goR <= 1'b0;
			if (write_unlock_cmd) begin
				bresp <= RESP_OKAY;
				if (awA == REG_CTRL) begin
					// A start while a frame runs is refused
					if (busy) begin
						bresp <= RESP_SLVERR;
					end else begin
						ctrlR <= mrg(ctrlR, wD, wS);
						goR   <= 1'b1;
					end
				end else if (awA == REG_ADDR) begin
					addrR <= mrg(addrR, wD, wS);
				end else if (awA == REG_LEN) begin
					lenR <= mrg(lenR, wD, wS);
				end else if (awA == REG_SEED) begin
					seedR <= mrg(seedR, wD, wS);
				end else begin
					bresp <= RESP_SLVERR;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{arready, rvalid, rdata, rresp} <= {1'b1, 35'h0};
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OKAY;
			if (araddr == REG_CTRL) begin
				rdata <= ctrlR;
			end else if (araddr == REG_ADDR) begin
				rdata <= addrR;
			end else if (araddr == REG_LEN) begin
				rdata <= lenR;
			end else if (araddr == REG_SEED) begin
				rdata <= seedR;
			end else if (araddr == REG_STAT) begin
				rdata <= {31'h0, busy};
			end else begin
				rdata <= 32'h0;
				rresp <= RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ****
	// Link sequencer
	// ****
	logic [7:0]  curR;
	logic [3:0]  bitR;
	logic [10:0] itemR;
	logic [2:0]  extraR;
	logic [3:0]  phR;
	logic [2:0]  nAddr;
	logic        quad, halfEnd;
	logic [3:0]  step;
	logic [10:0] itemsTot;
	logic [7:0]  nextByte;

	function automatic logic [3:0] lane(input logic [7:0] b, input logic q);
		return q ? b[7:4] : {3'h0, b[7]};
	endfunction : lane

	always_comb begin
		nAddr    = ctrlR[CTRL_NADDR_LSB +: 3];
		quad     = ctrlR[CTRL_QUAD_BIT];
		step     = quad ? 4'h4 : 4'h1;
		halfEnd  = (phR == 4'(SCK_HALF - 1));
		itemsTot = 11'h001 + {8'h00, nAddr} + {1'b0, lenR[9:0]};
		// Address bytes go most significant first
		if (itemR + 11'h001 <= {8'h00, nAddr}) begin
			nextByte = addrR[8*(2'({8'h00, nAddr} - itemR - 11'h001)) +: 8];
		end else begin
			nextByte = seedR[7:0] + 8'(itemR - {8'h00, nAddr});
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hsR       <= HS_IDLE;
			link.csN  <= 1'b1;
			link.sclk <= 1'b0;
			link.dq   <= 4'h0;
			curR      <= 8'h00;
			bitR      <= 4'h0;
			itemR     <= 11'h000;
			extraR    <= 3'h0;
			phR       <= 4'h0;
		end else begin
			case (hsR)
				HS_IDLE: begin
					if (goR) begin
						hsR      <= HS_SHIFT;
						link.csN <= 1'b0;
						curR     <= ctrlR[7:0];
						link.dq  <= lane(ctrlR[7:0], quad);
						bitR     <= 4'h8;
						itemR    <= 11'h000;
						extraR   <= ctrlR[CTRL_EXTRA_LSB +: 3];
						phR      <= 4'h0;
					end
				end
				HS_SHIFT: begin
					phR <= halfEnd ? 4'h0 : phR + 4'h1;
					if (halfEnd && !link.sclk) begin
						link.sclk <= 1'b1;
					end else if (halfEnd) begin
						// Data changes only while the clock is low
						link.sclk <= 1'b0;
						if (bitR > step) begin
							curR    <= curR << step;
							bitR    <= bitR - step;
							link.dq <= lane(curR << step, quad);
						end else if (itemR + 11'h001 < itemsTot) begin
							curR    <= nextByte;
							bitR    <= 4'h8;
							itemR   <= itemR + 11'h001;
							link.dq <= lane(nextByte, quad);
						end else if (extraR != 3'h0) begin
							extraR <= extraR - 3'h1;
							bitR   <= step;
						end else begin
							hsR <= HS_GAP;
							phR <= 4'h0;
						end
					end
				end
				default: begin
					phR <= phR + 4'h1;
					if (halfEnd) begin
						link.csN <= 1'b1;
					end
					if (phR == CS_GAP_CYC) begin
						hsR <= HS_IDLE;
					end
				end
			endcase
		end
	end

endmodule : sfp_host_end
`default_nettype wire

// ---- sfp_link_asserts.sv ----
// Property checks on the serial link and the flash end's status outputs
`timescale 1ns/1ps
`default_nettype none
module sfp_link_asserts
	import sfp_pkg::*;
(
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              csN,
	input wire logic              sclk,
	input wire logic [3:0]        dq,
	input wire logic              opInProgressFlag,
	input wire logic              writeLatch,
	input wire logic              cmdRejected,
	input wire logic              memErase,
	input wire sfp_kind_t         memKind,
	input wire logic [ADDR_W-1:0] memEraseAddr,
	input wire logic              memWr,
	input wire logic [ADDR_W-1:0] memWrAddr
);
	// ****
	// Link framing
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_high_phase;
		sclk[*4] ##1 !sclk;
	endsequence
	sequence s_begin;
		writeLatch && $rose(opInProgressFlag);
	endsequence
	AST_SCLK_IDLE: assert property (csN |-> !sclk)
		else $error("link clock moves while deselected");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high_phase)
		else $error("link clock high phase not four cycles");
	AST_DQ_HOLD: assert property (!csN && sclk |-> $stable(dq))
		else $error("data changed while link clock high");
	// ****
	// Internal cycle
	// ****
	AST_START_CS: assert property ($rose(opInProgressFlag) |-> csN && $past(csN, 2))
		else $error("busy began without select released");
	AST_START_LATCH: assert property ($rose(opInProgressFlag) |-> writeLatch)
		else $error("busy began with write latch clear");
	AST_BUSY_HOLD: assert property (s_begin |-> opInProgressFlag[*8])
		else $error("busy flag dropped early");
	AST_END_CLEAR: assert property ($fell(opInProgressFlag) |-> $fell(writeLatch))
		else $error("write latch not cleared with busy");
	AST_REJ_IDLE: assert property (cmdRejected |-> !opInProgressFlag ##1 !opInProgressFlag)
		else $error("rejected command started a cycle");
	AST_ERASE_START: assert property (memErase |-> $rose(opInProgressFlag) && memKind != K_PROG)
		else $error("erase strobe outside cycle start");
	AST_SECT_BASE: assert property (memErase && memKind == K_SECT |-> memEraseAddr[11:0] == 12'h000)
		else $error("sector base not aligned");
	AST_BLOCK_BASE: assert property (memErase && memKind == K_B64 |-> memEraseAddr[15:0] == 16'h0000)
		else $error("block base not aligned");
	AST_WR_COL: assert property (memWr && $past(memWr) |-> memWrAddr[7:0] > $past(memWrAddr[7:0])
		&& memWrAddr[ADDR_W-1:8] == $past(memWrAddr[ADDR_W-1:8]))
		else $error("page write left its page");
endmodule : sfp_link_asserts
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench: host end and flash end joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench
	import sfp_pkg::*;
;
	// ****
	// Signals and instances
	// ****
	localparam int SMALL_US = 3;
	localparam int LARGE_US = 4;
	localparam int ARRAY_US = 5;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [7:0]        awaddr, araddr, memWrData;
	logic [31:0]       wdata, rdata, d;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r;
	logic              addr4Mode, quadCmdMode, perBlockLockMode;
	logic [4:0]        protectLevel;
	logic              opInProgressFlag, writeLatch, cmdRejected, memErase, memWr;
	sfp_kind_t         memKind, ersKind;
	logic [ADDR_W-1:0] memEraseAddr, memWrAddr, ersAddr;
	logic [7:0]        colData [256];
	int                fails, numChecks, rejCnt, ersCnt, wrCnt;
	int                busyRun, busyLen, rBase, eBase;
	logic [7:0]        ops [8] = '{OP_SE, OP_SE_W, OP_B32, OP_B32_W,
		OP_B64, OP_B64_W, OP_CE0, OP_CE1};
	sfp_kind_t         kinds [8] = '{K_SECT, K_SECT, K_B32, K_B32,
		K_B64, K_B64, K_CHIP, K_CHIP};
	int                lsbs [8] = '{12, 12, 15, 15, 16, 16, 26, 26};
	int                uss [8] = '{SMALL_US, SMALL_US, LARGE_US, LARGE_US,
		LARGE_US, LARGE_US, ARRAY_US, ARRAY_US};
	sfp_link_if link ();
	sfp_host_end sfp_host_end_i (.clk, .rstn, .link, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	sfp_flash_end #(.SMALL_WIPE_US(SMALL_US), .LARGE_WIPE_US(LARGE_US),
		.ARRAY_WIPE_US(ARRAY_US), .PAGE_WRITE_US(SMALL_US)) sfp_flash_end_i (
		.clk, .rstn, .link, .addr4Mode, .quadCmdMode, .protectLevel,
		.perBlockLockMode, .opInProgressFlag, .writeLatch, .cmdRejected,
		.memErase, .memKind, .memEraseAddr, .memWr, .memWrAddr, .memWrData);
	sfp_link_asserts sfp_link_asserts_i (.clk, .rstn, .csN(link.csN),
		.sclk(link.sclk), .dq(link.dq), .opInProgressFlag, .writeLatch,
		.cmdRejected, .memErase, .memKind, .memEraseAddr, .memWr, .memWrAddr);
	always #5 clk = ~clk;
	// Log of one-cycle pulses and of the busy run length
	always @(posedge clk) begin
		if (cmdRejected === 1'b1) rejCnt++;
		if (memErase === 1'b1) begin
			ersCnt++;
			ersKind = memKind;
			ersAddr = memEraseAddr;
		end
		if (memWr === 1'b1) begin
			wrCnt++;
			colData[memWrAddr[7:0]] = memWrData;
		end
		if (opInProgressFlag === 1'b1) busyRun++;
		else if (busyRun != 0) begin
			busyLen = busyRun;
			busyRun = 0;
		end
	end
	// ****
	// Tasks
	// ****
	task automatic summarize;
		if (fails == 0 && numChecks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tout;
		fails++;
		$display("mismatch at %0t: wait ran out", $time);
		summarize();
	endtask : tout
	task automatic axiWr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 99);
		bready <= 1'b0;
		if (n >= 99) tout();
		check(bresp, e);
	endtask : axiWr
	task automatic axiRd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 99);
		rready <= 1'b0;
		v = rdata;
		e = rresp;
		if (n >= 99) tout();
	endtask : axiRd
	// Start a frame, poll until closed
	task automatic cmd(input logic [7:0] op, input logic [2:0] na,
		input logic [31:0] a, input logic [9:0] len, input logic [2:0] ex);
		int n;
		axiWr(REG_ADDR, a, RESP_OKAY);
		axiWr(REG_LEN, {22'h0, len}, RESP_OKAY);
		axiWr(REG_CTRL, {13'h0, ex, 3'h0, quadCmdMode, 1'b0, na, op}, RESP_OKAY);
		n = 0;
		do begin
			axiRd(REG_STAT, d, r);
			n++;
		end while (d[0] !== 1'b0 && n < 9999);
		if (n >= 9999) tout();
		repeat (8) @(posedge clk);
	endtask : cmd
	task automatic unlock;
		cmd(OP_UNLOCK, 3'h0, 32'h0, 10'h0, 3'h0);
	endtask : unlock
	task automatic waitIdle(input int cyc);
		int n;
		n = 0;
		while (opInProgressFlag !== 1'b0 && n < 9999) begin
			@(posedge clk);
			n++;
		end
		if (n >= 9999) tout();
		@(posedge clk);
		check(busyLen, cyc);
		check(writeLatch, 1'b0);
	endtask : waitIdle
	task automatic erase(input logic [7:0] op, input logic [2:0] na,
		input logic [31:0] a, input sfp_kind_t k, input int lsb, input int us);
		int e0;
		unlock();
		e0 = ersCnt;
		cmd(op, na, a, 10'h0, 3'h0);
		check(ersCnt - e0, 1);
		check(ersKind, k);
		check(ersAddr, a[ADDR_W-1:0] >> lsb << lsb);
		waitIdle(us * 100);
	endtask : erase
	task automatic rej(input logic [7:0] op, input logic [2:0] na,
		input logic [31:0] a, input logic [9:0] len, input logic [2:0] ex);
		int r0, e0;
		r0 = rejCnt;
		e0 = ersCnt + wrCnt;
		cmd(op, na, a, len, ex);
		check(rejCnt - r0, 1);
		check(ersCnt + wrCnt - e0, 0);
	endtask : rej
	task automatic page(input logic [7:0] op, input logic [2:0] na,
		input logic [31:0] a, input int len);
		int w0;
		unlock();
		w0 = wrCnt;
		cmd(op, na, a, len[9:0], 3'h0);
		waitIdle(SMALL_US * 100);
		check(wrCnt - w0, len > 256 ? 256 : len);
		for (int k = 0; k < len; k++)
			check(colData[8'(a[7:0] + k)], 8'(8'h10 + k));
	endtask : page
	// ****
	// Sequence
	// ****
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
		{addr4Mode, quadCmdMode, perBlockLockMode, protectLevel} = 8'h00;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		axiWr(REG_SEED, 32'h10, RESP_OKAY);
		axiWr(8'h40, 32'h0, RESP_SLVERR);
		axiRd(8'h44, d, r);
		check({r, d}, {RESP_SLVERR, 32'h0});
		rej(OP_SE, NARROW_BYTES, 32'h123456, 10'h0, 3'h0);
		for (int i = 0; i < 8; i++)
			erase(ops[i], i > 5 ? 3'h0 : i[0] ? WIDE_BYTES : NARROW_BYTES,
				i[0] ? 32'h2123456 : 32'h123456, kinds[i], lsbs[i], uss[i]);
		addr4Mode <= 1'b1;
		erase(OP_SE, WIDE_BYTES, 32'h3123456, K_SECT, 12, SMALL_US);
		addr4Mode <= 1'b0;
		unlock();
		rej(OP_SE, NARROW_BYTES, 32'h1000, 10'h0, 3'h1);
		protectLevel <= 5'h0b;
		unlock();
		rej(OP_B64, NARROW_BYTES, 32'h1000, 10'h0, 3'h0);
		protectLevel <= 5'h01;
		rej(OP_SE_W, WIDE_BYTES, 32'h3ff1234, 10'h0, 3'h0);
		rej(OP_CE1, 3'h0, 32'h0, 10'h0, 3'h0);
		{protectLevel, perBlockLockMode} <= 6'h01;
		unlock();
		rej(OP_CE0, 3'h0, 32'h0, 10'h0, 3'h0);
		cmd(OP_GUNLOCK, 3'h0, 32'h0, 10'h0, 3'h0);
		erase(OP_CE0, 3'h0, 32'h0, K_CHIP, 26, ARRAY_US);
		perBlockLockMode <= 1'b0;
		unlock();
		rej(OP_PP, NARROW_BYTES, 32'h100, 10'h0, 3'h0);
		unlock();
		rej(OP_PP, NARROW_BYTES, 32'h100, 10'h1, 3'h3);
		page(OP_PP, NARROW_BYTES, 32'hf0, 20);
		page(OP_PP_W, WIDE_BYTES, 32'h1000000, 260);
		quadCmdMode <= 1'b1;
		erase(OP_B32, NARROW_BYTES, 32'ha5a5a, K_B32, 15, LARGE_US);
		quadCmdMode <= 1'b0;
		unlock();
		cmd(OP_CE0, 3'h0, 32'h0, 10'h0, 3'h0);
		{rBase, eBase} = {rejCnt, ersCnt};
		cmd(OP_SE, NARROW_BYTES, 32'h1000, 10'h0, 3'h0);
		check(ersCnt - eBase, 0);
		check(rejCnt - rBase, 0);
		waitIdle(ARRAY_US * 100);
		summarize();
	end
endmodule : testbench
`default_nettype wire
